// *** design/omec_consts.vh ***
// Register indices, field positions, keys and timing figures of the mode entry block
`ifndef OMEC_CONSTS_VH
`define OMEC_CONSTS_VH

// Register indices; byte address is four times the index
`define OMEC_IDX_CELL_CTRL 8'h08
`define OMEC_IDX_CHECK_STATUS 8'h0B
`define OMEC_IDX_ENTRY_KEY 8'h2A
`define OMEC_IDX_VALIDATE_KEY 8'h36
`define OMEC_IDX_PROGRAM_CMD 8'h39
`define OMEC_IDX_EVT_STATUS 8'h40
`define OMEC_IDX_EVT_MASK 8'h41
`define OMEC_IDX_MODE_STATUS 8'h42

// Key and command codes
`define OMEC_ENTRY_KEY 8'h3C
`define OMEC_VALIDATE_KEY 8'h96
`define OMEC_START_CMD 8'hB0

// Field positions
`define OMEC_BIT_CELL_SEL 0
`define OMEC_BIT_AUTO_MODE 7
`define OMEC_BIT_SLOW_WRITE 6
`define OMEC_BIT_CUST_LOCK 4
`define OMEC_BIT_BANK_LOCK 3
`define OMEC_BIT_ACTIVE 2
`define OMEC_BIT_MODE_ARMED 0
`define OMEC_BIT_MODE_VALID 1

// Event bits
`define OMEC_EVT_W 3
`define OMEC_EVT_DONE 0
`define OMEC_EVT_REFUSED 1
`define OMEC_EVT_MODE_EXIT 2

// Reset values
`define OMEC_RST_CELL_SEL 1'b1
`define OMEC_RST_AUTO_MODE 1'b0
`define OMEC_RST_SLOW_WRITE 1'b0

// Timing
`define OMEC_FAST_WRITE_MS 100
`define OMEC_SLOW_WRITE_MS 200
`define OMEC_CLK_KHZ 100000
`define OMEC_FAST_WRITE_CYCLES (`OMEC_FAST_WRITE_MS * `OMEC_CLK_KHZ)
`define OMEC_SLOW_WRITE_CYCLES (`OMEC_SLOW_WRITE_MS * `OMEC_CLK_KHZ)

`endif

// *** design/omec_sync2.v ***
// Two-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none
module omec_sync2 #(
	parameter W = 1
) (
	input wire hclk,
	input wire hresetn,
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// First stage feeds only the second stage
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule
`default_nettype wire

// *** design/omec_prog_timer.v ***
// Programming pulse timer with fast and slow durations
`timescale 1ns/10ps
`default_nettype none
module omec_prog_timer #(
	parameter [31:0] FAST_CYCLES = 32'd10000000,
	parameter [31:0] SLOW_CYCLES = 32'd20000000
) (
	input wire hclk,
	input wire hresetn,
	input wire start,
	input wire slow,
	output reg busy_q,
	output reg done_q
);
	reg [31:0] cnt_q;

	// Busy for exactly the chosen count; duration latched at start
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 32'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start && !busy_q) begin
				cnt_q <= (slow ? SLOW_CYCLES : FAST_CYCLES) - 32'd1;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (cnt_q == 32'h0) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 32'd1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** design/omec_mode_entry_ctrl.v ***
// Programming mode entry, start command and status for one-time cells
`timescale 1ns/10ps
`default_nettype none
`include "omec_consts.vh"
module omec_mode_entry_ctrl #(
	parameter [31:0] FAST_CYCLES = `OMEC_FAST_WRITE_CYCLES,
	parameter [31:0] SLOW_CYCLES = `OMEC_SLOW_WRITE_CYCLES
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata_q,
	output reg hreadyout_q,
	output reg hresp_q,
	input wire customer_lock_pin,
	input wire bank_lock_pin,
	output reg irq_q,
	output reg prog_mode_q,
	output wire cell_write_en,
	output reg cell_slow_select_q,
	output reg cell_transparency_select_q
);
	// Bus phase registers
	reg wr_pend_q;
	reg rd_pend_q;
	reg hit_q;
	reg [7:0] idx_q;

	// Control and state
	reg armed_q;
	reg auto_mode_q;
	reg bank_lock_q;
	reg [`OMEC_EVT_W-1:0] evt_sts_q;
	reg [`OMEC_EVT_W-1:0] evt_mask_q;

	// Combinational
	wire addr_ok;
	wire addr_in_map;
	wire addr_aligned;
	wire wr_hit;
	wire [7:0] wdat;
	wire entry_wr;
	wire validate_wr;
	wire cmd_wr;
	wire start_req;
	wire start_ok;
	wire refused;
	wire mode_exit;
	wire seq_busy;
	wire seq_done;
	wire cust_lock;
	wire bank_pin_lock;
	wire [`OMEC_EVT_W-1:0] evt_set;
	wire [`OMEC_EVT_W-1:0] evt_sts_d;
	wire irq_d;
	// Per-register write strobes
	wire cell_ctrl_wr;
	wire check_sts_wr;
	wire evt_sts_wr;
	wire evt_mask_wr;
	// Combinational next values
	reg [`OMEC_EVT_W-1:0] evt_clr;
	reg armed_d;
	reg prog_mode_d;
	reg [7:0] rd_mux;

	// Lock pins come from the cell array, outside this clock
	omec_sync2 #(
		.W(2)
	) u_lock_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d({customer_lock_pin, bank_lock_pin}),
		.q({cust_lock, bank_pin_lock})
	);

	// Programming pulse duration
	omec_prog_timer #(
		.FAST_CYCLES(FAST_CYCLES),
		.SLOW_CYCLES(SLOW_CYCLES)
	) u_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(start_ok),
		.slow(cell_slow_select_q),
		.busy_q(seq_busy),
		.done_q(seq_done)
	);

	assign cell_write_en = seq_busy;

	// Address phase capture; only aligned words low in the map hit
	assign addr_ok = hsel && htrans[1] && hready;
	assign addr_in_map = (haddr[31:10] == 22'h0);
	assign addr_aligned = (haddr[1:0] == 2'h0);

	// Pipeline the address phase into the data phase

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			hit_q <= 1'b0;
			idx_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_ok && hwrite;
			rd_pend_q <= addr_ok && !hwrite;
			if (addr_ok) begin
				hit_q <= addr_in_map && addr_aligned;
				idx_q <= haddr[9:2];
			end
		end
	end

	// Reads take one wait state so data reflects any write just finished
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			hrdata_q <= 32'h0;
		end else begin
			hresp_q <= 1'b0;
			hreadyout_q <= !(addr_ok && !hwrite);
			if (rd_pend_q) begin
				hrdata_q <= {24'h0, rd_mux};
			end
		end
	end

	// Read mux; write-only and unmapped words read zero
	always @* begin
		rd_mux = 8'h00;
		if (hit_q) begin
			case (idx_q)
				`OMEC_IDX_CELL_CTRL: begin
					rd_mux[`OMEC_BIT_CELL_SEL] = cell_transparency_select_q;
				end
				`OMEC_IDX_CHECK_STATUS: begin
					rd_mux[`OMEC_BIT_AUTO_MODE] = auto_mode_q;
					rd_mux[`OMEC_BIT_SLOW_WRITE] = cell_slow_select_q;
					rd_mux[`OMEC_BIT_CUST_LOCK] = cust_lock;
					rd_mux[`OMEC_BIT_BANK_LOCK] = bank_lock_q;
					rd_mux[`OMEC_BIT_ACTIVE] = seq_busy;
				end
				`OMEC_IDX_EVT_STATUS: begin
					rd_mux[`OMEC_EVT_W-1:0] = evt_sts_q;
				end
				`OMEC_IDX_EVT_MASK: begin
					rd_mux[`OMEC_EVT_W-1:0] = evt_mask_q;
				end
				`OMEC_IDX_MODE_STATUS: begin
					rd_mux[`OMEC_BIT_MODE_ARMED] = armed_q;
					rd_mux[`OMEC_BIT_MODE_VALID] = prog_mode_q;
				end
				default: begin
					rd_mux = 8'h00;
				end
			endcase
		end
	end

	// Write decode; data taken in the data phase
	assign wr_hit = wr_pend_q && hit_q;
	assign wdat = hwdata[7:0];
	assign entry_wr = wr_hit && (idx_q == `OMEC_IDX_ENTRY_KEY);
	assign validate_wr = wr_hit && (idx_q == `OMEC_IDX_VALIDATE_KEY);
	assign cmd_wr = wr_hit && (idx_q == `OMEC_IDX_PROGRAM_CMD);
	assign cell_ctrl_wr = wr_hit && (idx_q == `OMEC_IDX_CELL_CTRL);
	assign check_sts_wr = wr_hit && (idx_q == `OMEC_IDX_CHECK_STATUS);
	assign evt_sts_wr = wr_hit && (idx_q == `OMEC_IDX_EVT_STATUS);
	assign evt_mask_wr = wr_hit && (idx_q == `OMEC_IDX_EVT_MASK);

	// Key sequence: entry arms, matching validation completes, else exit
	always @* begin
		armed_d = armed_q;
		prog_mode_d = prog_mode_q;
		if (entry_wr) begin
			armed_d = (wdat == `OMEC_ENTRY_KEY);
		end
		if (validate_wr) begin
			armed_d = 1'b0;
			if (wdat == `OMEC_VALIDATE_KEY) begin
				prog_mode_d = prog_mode_q || armed_q;
			end else begin
				prog_mode_d = 1'b0;
			end
		end
	end

	// Exit event only when there was something to leave; a stray bad key while idle stays silent
	assign mode_exit = validate_wr
		&& (wdat != `OMEC_VALIDATE_KEY)
		&& (prog_mode_q || armed_q);

	// Start gating: validated, idle and no lock present
	assign start_req = cmd_wr && (wdat == `OMEC_START_CMD);
	assign start_ok = start_req
		&& prog_mode_q
		&& !seq_busy
		&& !cust_lock
		&& !bank_lock_q;
	// Refused starts are reported, other command values are dropped silently
	assign refused = start_req && !start_ok;

	// Key sequence registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_q <= 1'b0;
			prog_mode_q <= 1'b0;
		end else begin
			armed_q <= armed_d;
			prog_mode_q <= prog_mode_d;
		end
	end

	// Configuration bits; duration is latched by the timer, so mid-run changes are harmless
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			auto_mode_q <= `OMEC_RST_AUTO_MODE;
			cell_slow_select_q <= `OMEC_RST_SLOW_WRITE;
		end else if (check_sts_wr) begin
			auto_mode_q <= wdat[`OMEC_BIT_AUTO_MODE];
			cell_slow_select_q <= wdat[`OMEC_BIT_SLOW_WRITE];
		end
	end

	// Host must leave this at one before burning cells; hardware does not check it
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cell_transparency_select_q <= `OMEC_RST_CELL_SEL;
		end else if (cell_ctrl_wr) begin
			cell_transparency_select_q <= wdat[`OMEC_BIT_CELL_SEL];
		end
	end

	// Bank lock is sticky: a finished burn or the array's own flag
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bank_lock_q <= 1'b0;
		end else if (seq_done || bank_pin_lock) begin
			bank_lock_q <= 1'b1;
		end
	end

	// Clear mask only from a write to the event status word
	always @* begin
		evt_clr = {`OMEC_EVT_W{1'b0}};
		if (evt_sts_wr) begin
			evt_clr = wdat[`OMEC_EVT_W-1:0];
		end
	end

	// Sticky events, write one to clear, a new event wins over the clear
	assign evt_set = {mode_exit, refused, seq_done};
	assign evt_sts_d = (evt_sts_q & ~evt_clr) | evt_set;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt_sts_q <= {`OMEC_EVT_W{1'b0}};
		end else begin
			evt_sts_q <= evt_sts_d;
		end
	end

	// Mask register; a zero bit keeps its event off the line
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt_mask_q <= {`OMEC_EVT_W{1'b0}};
		end else if (evt_mask_wr) begin
			evt_mask_q <= wdat[`OMEC_EVT_W-1:0];
		end
	end

	// Registered so the pin never glitches; lags status by one cycle
	assign irq_d = |(evt_sts_q & evt_mask_q);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end
endmodule
`default_nettype wire

// *** testbench/omec_checker.sv ***
// Port assertions for the mode entry block
`timescale 1ns/10ps
`default_nettype none
module omec_checker #(
	parameter [31:0] FAST_CYCLES = 32'd20,
	parameter [31:0] SLOW_CYCLES = 32'd40
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata_q,
	input wire hreadyout_q,
	input wire customer_lock_pin,
	input wire prog_mode_q,
	input wire cell_write_en,
	input wire cell_slow_select_q
);
	logic wv_q, slw_q, ds_q, cw_q;
	logic [9:0] a_q;
	logic [31:0] cnt_q;
	// Completed write data phases decoded by address and value
	wire wt = wv_q && hready;
	wire sw = wt && a_q == 10'h0E4 && hwdata[7:0] == 8'hB0;
	wire vg = wt && a_q == 10'h0D8 && hwdata[7:0] == 8'h96;
	wire vb = wt && a_q == 10'h0D8 && hwdata[7:0] != 8'h96;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Bus phase tracking; slow select kept only while idle, as the run samples it at start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wv_q <= 1'b0;
			a_q <= 10'h000;
			slw_q <= 1'b0;
			ds_q <= 1'b0;
			cw_q <= 1'b0;
			cnt_q <= 32'h0;
		end else begin
			wv_q <= hsel && htrans[1] && hready && hwrite;
			if (hsel && htrans[1] && hready) a_q <= haddr[9:0];
			cw_q <= cell_write_en;
			ds_q <= ds_q || (cw_q && !cell_write_en);
			cnt_q <= cell_write_en ? cnt_q + 32'h1 : 32'h0;
			if (!cell_write_en) slw_q <= cell_slow_select_q;
		end
	end
	a_entry_valid: assert property ($rose(prog_mode_q) |-> $past(vg)) else $error("mode set without key");
	a_bad_key_exit: assert property (vb |=> !prog_mode_q) else $error("mode kept on bad key");
	a_start_cmd: assert property ($rose(cell_write_en) |-> $past(sw)) else $error("run without command");
	a_run_flag: assert property ($rose(hreadyout_q) && a_q == 10'h02C |-> hrdata_q[2] == $past(cell_write_en))
		else $error("active bit wrong");
	a_lock_after_run: assert property ($rose(hreadyout_q) && a_q == 10'h02C && $past(ds_q) |-> hrdata_q[3])
		else $error("lock bit clear after run");
	a_run_length: assert property ($fell(cell_write_en) |-> cnt_q == (slw_q ? SLOW_CYCLES : FAST_CYCLES))
		else $error("run length wrong");
	a_cust_lock: assert property ($rose(cell_write_en) |-> !$past(customer_lock_pin, 3))
		else $error("run while locked");
	a_start_gate: assert property ($rose(cell_write_en) |-> $past(prog_mode_q) && !ds_q)
		else $error("run outside mode");
endmodule
`default_nettype wire

// *** testbench/omec_host.sv ***
// Programming host model on the register bus
`timescale 1ns/10ps
`default_nettype none
module omec_host (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [31:0] hwdata
);
	// Bus idle at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
	end
	// Single word transfer; each phase held until hready is seen high
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		r = hrdata;
	endtask
	// Key pair, then cells made opaque before any start
	task automatic enter;
		logic [31:0] r;
		xfer(1'b1, 32'hA8, 32'h3C, r);
		xfer(1'b1, 32'hD8, 32'h96, r);
		xfer(1'b1, 32'h20, 32'h1, r);
	endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the mode entry block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int FC = 20;
	localparam int SC = 40;
	typedef struct {logic [31:0] a; logic [31:0] d; logic [7:0] e;} omec_row_t;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic cust_pin = 1'b0;
	logic bank_pin = 1'b0;
	logic cell_slow_select_q, cell_transparency_select_q;
	logic hsel, hwrite, hreadyout_q, hresp_q, irq_q, prog_mode_q, cell_write_en;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata_q, r;
	int error_cnt = 0;
	int checked = 0;
	int n;
	// Write then read back; write-only, read-only and unmapped places included
	omec_row_t rows[6] = '{'{32'h20, 32'h0, 8'h00}, '{32'h2C, 32'hDF, 8'hC0}, '{32'hA8, 32'h3C, 8'h00},
		'{32'h108, 32'h0, 8'h01}, '{32'h104, 32'h7, 8'h07}, '{32'h3FC, 32'hFF, 8'h00}};
	always #5 hclk = ~hclk;
	omec_host host_u (.hclk, .hready(hreadyout_q), .hrdata(hrdata_q), .hsel, .haddr, .htrans, .hwrite, .hwdata);
	omec_mode_entry_ctrl #(.FAST_CYCLES(FC), .SLOW_CYCLES(SC)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout_q), .hrdata_q, .hreadyout_q, .hresp_q,
		.customer_lock_pin(cust_pin), .bank_lock_pin(bank_pin), .irq_q, .prog_mode_q, .cell_write_en,
		.cell_slow_select_q, .cell_transparency_select_q);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic rst;
		hresetn <= 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask
	// Start command; the caller decides how long to watch the run
	task automatic start;
		host_u.xfer(1'b1, 32'hE4, 32'hB0, r);
	endtask
	initial begin
		rst;
		foreach (rows[i]) begin
			host_u.xfer(1'b1, rows[i].a, rows[i].d, r);
			host_u.xfer(1'b0, rows[i].a, 32'h0, r);
			chk(r, {24'h0, rows[i].e});
		end
		chk(32'(cell_transparency_select_q), 32'h0);
		chk(32'(cell_slow_select_q), 32'h1);
		start;
		repeat (4) @(posedge hclk);
		chk(32'(cell_write_en), 32'h0);
		// Wrong entry value disarms, so a good validation key alone does nothing
		host_u.xfer(1'b1, 32'hA8, 32'h11, r);
		host_u.xfer(1'b1, 32'hD8, 32'h96, r);
		@(posedge hclk);
		chk(32'(prog_mode_q), 32'h0);
		host_u.enter;
		chk(32'(prog_mode_q), 32'h1);
		@(posedge hclk);
		chk(32'(cell_transparency_select_q), 32'h1);
		chk(32'(hresp_q), 32'h0);
		host_u.xfer(1'b1, 32'hD8, 32'h55, r);
		@(posedge hclk);
		chk(32'(prog_mode_q), 32'h0);
		host_u.xfer(1'b0, 32'h100, 32'h0, r);
		chk(r, 32'h6);
		chk(32'(irq_q), 32'h1);
		host_u.xfer(1'b1, 32'h100, 32'h6, r);
		host_u.xfer(1'b0, 32'h100, 32'h0, r);
		chk(r, 32'h0);
		chk(32'(irq_q), 32'h0);
		// Slow run, then a second start that the bank lock must refuse
		host_u.enter;
		start;
		host_u.xfer(1'b0, 32'h2C, 32'h0, r);
		chk(r, 32'hC4);
		for (n = 0; n < 99 && cell_write_en; n++) @(posedge hclk);
		host_u.xfer(1'b0, 32'h2C, 32'h0, r);
		chk(r, 32'hC8);
		start;
		repeat (4) @(posedge hclk);
		chk(32'(cell_write_en), 32'h0);
		host_u.xfer(1'b0, 32'h100, 32'h0, r);
		chk(r, 32'h3);
		// Customer lock blocks, then a fast run once it is lifted
		cust_pin <= 1'b1;
		rst;
		chk(32'(prog_mode_q), 32'h0);
		chk(32'(cell_transparency_select_q), 32'h1);
		chk(32'(cell_slow_select_q), 32'h0);
		chk(32'(irq_q), 32'h0);
		chk(32'(hreadyout_q), 32'h1);
		host_u.enter;
		start;
		repeat (4) @(posedge hclk);
		chk(32'(cell_write_en), 32'h0);
		cust_pin <= 1'b0;
		repeat (4) @(posedge hclk);
		start;
		for (n = 0; n < 8 && !cell_write_en; n++) @(posedge hclk);
		for (n = 0; n < 99 && cell_write_en; n++) @(posedge hclk);
		chk(32'(n), 32'(FC));
		chk(32'(prog_mode_q), 32'h1);
		// Lock raised by the array pin alone, after a fresh reset
		bank_pin <= 1'b1;
		rst;
		repeat (4) @(posedge hclk);
		host_u.xfer(1'b0, 32'h2C, 32'h0, r);
		chk(r, 32'h08);
		end_of_test;
	end
	// Watchdog well beyond the expected run of under a thousand cycles
	initial begin
		repeat (5000) @(posedge hclk);
		error_cnt++;
		end_of_test;
	end
endmodule
bind omec_mode_entry_ctrl omec_checker #(.FAST_CYCLES(FAST_CYCLES), .SLOW_CYCLES(SLOW_CYCLES)) chk_u (.hclk,
	.hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata_q, .hreadyout_q, .customer_lock_pin,
	.prog_mode_q, .cell_write_en, .cell_slow_select_q);
`default_nettype wire
